// file: shared/bso_consts.vh
`ifndef BSO_CONSTS_VH
`define BSO_CONSTS_VH
// register byte offsets
`define BSO_OFF_CTRL 12'h000
`define BSO_OFF_CFG 12'h004
`define BSO_OFF_STATUS 12'h008
`define BSO_OFF_IRQ_STAT 12'h00c
`define BSO_OFF_IRQ_MASK 12'h010
`define BSO_OFF_ERRCODE 12'h014
`define BSO_OFF_TICKDIV 12'h018
// ctrl fields
`define BSO_CTRL_FAULT 0
`define BSO_CTRL_UNLOCK 1
`define BSO_CTRL_COOL 2
`define BSO_CTRL_PCHG 3
// cfg fields
`define BSO_CFG_GREASE 0
`define BSO_CFG_PREIGN 1
`define BSO_CFG_RELIGHT 2
`define BSO_CFG_AIRMODE 3
`define BSO_CFG_PAUSE_FAULT 4
`define BSO_CFG_OPFN_LSB 8
`define BSO_CFG_OPFN_MSB 9
// operation output function selections
`define BSO_OPFN_OFF 2'h0
`define BSO_OPFN_RUN 2'h1
`define BSO_OPFN_GREASE 2'h2
`define BSO_OPFN_READY 2'h3
// irq bits
`define BSO_IRQ_ERROR 0
`define BSO_IRQ_RESTART 1
`define BSO_IRQ_TIMEOUT 2
`define BSO_IRQ_W 3
// timing: timebase rate, clock and reset divisor, then durations in seconds of the timebase
`define BSO_TICK_HZ 32'd1
`define BSO_CLK_HZ 32'd50000000
`define BSO_TICKDIV_RST 32'd49999999
`define BSO_PAUSE_SEC 16'd1800
`define BSO_AIRCHK_SEC 16'd120
`define BSO_CHAIN_SEC 16'd60
// program state codes
`define BSO_ST_ERROR 8'h00
`define BSO_ST_PAUSE1 8'h01
`define BSO_ST_PAUSE5 8'h05
`define BSO_ST_WAIT 8'h02
`define BSO_ST_AIRCHK 8'h03
`define BSO_ST_CHAIN 8'h04
`define BSO_ST_WDOG 8'h05
`define BSO_ST_CHAIN_FAIL 8'h25
// program phases beyond this block, given as inputs
`define BSO_PH_PREAER 3'h1
`define BSO_PH_IGNITE 3'h2
`define BSO_PH_STAB 3'h3
`define BSO_PH_OPER 3'h4
`define BSO_PH_SHUT 3'h5
`endif

// file: core/bso_top.v
// What this block does
// - pressure build valve open only in pre-aeration
// - vent closed pre-aeration through stabilisation
// - ignition from state, optional pre-ignition
// - pilot relight restarts ignition burner
// - fan from state, cooling in fault/wait
// - operation output per function selection
// - alarm high in fault or lockout
// - error state shows error code
// - parameter mode halts, unlock steps
// - 30 minute pause timeout restart/fault
// - leave manual only after fifth pause
// - state two ready, waits heat request
// - air switch idle check, 2 min
// - safety chain free check, 1 min
// - watchdog loading, chain break to 25
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "bso_consts.vh"
module bso_top
(
    input wire SYS_CLK,
    input wire ARST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire PARAM_MODE,
    input wire HEAT_REQ,
    input wire AIR_PRESSURE_SWITCH,
    input wire SAFETY_CHAIN,
    input wire LOCKED_OUT,
    input wire MAIN_OFF_REQ,
    input wire [2:0] LATER_PHASE,
    output reg PRESSURE_BUILD_VALVE,
    output reg VENT_VALVE,
    output reg IGNITION_OUTPUT,
    output reg FAN_AIR_VALVE_OUTPUT,
    output reg OPERATION_OUTPUT,
    output reg ALARM_OUTPUT,
    output reg WATCHDOG_ENABLE,
    output reg ERROR_PRESENT,
    output reg READY_OUT,
    output reg [7:0] DISPLAY_CODE,
    output reg IRQ
);

localparam S_ERROR = 7'b0000001;
localparam S_PAUSE = 7'b0000010;
localparam S_WAIT = 7'b0000100;
localparam S_AIRCHK = 7'b0001000;
localparam S_CHAIN = 7'b0010000;
localparam S_WDOG = 7'b0100000;
localparam S_LATER = 7'b1000000;

reg [6:0] state_r;
reg [6:0] state_nxt;
reg [2:0] pause_r;
reg [2:0] pause_nxt;
reg [15:0] sec_r;
reg [31:0] div_r;
reg tick_r;
reg [3:0] ctrl_r;
reg [9:0] cfg_r;
reg [2:0] irq_stat_r;
reg [2:0] irq_mask_r;
reg [7:0] errcode_r;
reg [31:0] tickdiv_r;
reg [2:0] ev_nxt;
reg relight_r;
reg [7:0] code_nxt;

wire wr_acc = PSEL & PENABLE & PWRITE;
wire rd_setup = PSEL & ~PENABLE & ~PWRITE;
wire unlock_pulse = wr_acc & (PADDR == `BSO_OFF_CTRL) & PWDATA[`BSO_CTRL_UNLOCK];
wire [1:0] opfn = cfg_r[`BSO_CFG_OPFN_MSB:`BSO_CFG_OPFN_LSB];
wire [7:0] pause_code = {5'h00, pause_r};
wire air_idle = AIR_PRESSURE_SWITCH ^ cfg_r[`BSO_CFG_AIRMODE];
wire in_preaer = (state_r == S_LATER) & (LATER_PHASE == `BSO_PH_PREAER);
wire in_grease_win = (state_r == S_LATER) & (LATER_PHASE >= `BSO_PH_PREAER)
    & (LATER_PHASE <= `BSO_PH_STAB);

function addr_ok;
    input [11:0] a;
    begin
        addr_ok = (a[1:0] == 2'h0) & (a <= `BSO_OFF_TICKDIV);
    end
endfunction

function timed_out;
    input [15:0] secs;
    input [15:0] limit;
    begin
        timed_out = secs >= limit;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// timebase: one tick per second, divisor programmable for simulation
always @(posedge SYS_CLK or negedge ARST_N)
begin
    if (!ARST_N)
    begin
        div_r <= 32'h00000000;
        tick_r <= 1'b0;
    end
    else if (div_r >= tickdiv_r)
    begin
        div_r <= 32'h00000000;
        tick_r <= 1'b1;
    end
    else
    begin
        div_r <= div_r + 32'h00000001;
        tick_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer
always @*
begin
    state_nxt = state_r;
    pause_nxt = pause_r;
    ev_nxt = 3'h0;
    case (state_r)
        S_ERROR:
        begin
            if (!ctrl_r[`BSO_CTRL_FAULT] && unlock_pulse && !LOCKED_OUT)
                state_nxt = S_WAIT;
        end
        S_PAUSE:
        begin
            if (timed_out(sec_r, `BSO_PAUSE_SEC))
            begin
                ev_nxt[`BSO_IRQ_TIMEOUT] = 1'b1;
                state_nxt = cfg_r[`BSO_CFG_PAUSE_FAULT] ? S_ERROR : S_WAIT;
                pause_nxt = 3'h1;
            end
            else if (!PARAM_MODE)
            begin
                // early exit with changed params keeps them unreleased
                if (pause_code < `BSO_ST_PAUSE5 && ctrl_r[`BSO_CTRL_PCHG])
                    state_nxt = S_ERROR;
                else if (pause_code == `BSO_ST_PAUSE5)
                    state_nxt = S_WAIT;
            end
            else if (unlock_pulse && pause_code != `BSO_ST_PAUSE5)
                pause_nxt = pause_r + 3'h1;
        end
        S_WAIT:
        begin
            if (PARAM_MODE)
            begin
                state_nxt = S_PAUSE;
                pause_nxt = 3'h1;
            end
            else if (HEAT_REQ)
                state_nxt = S_AIRCHK;
        end
        S_AIRCHK:
        begin
            if (air_idle)
                state_nxt = S_CHAIN;
            else if (timed_out(sec_r, `BSO_AIRCHK_SEC))
            begin
                ev_nxt[`BSO_IRQ_RESTART] = 1'b1;
                state_nxt = S_WAIT;
            end
        end
        S_CHAIN:
        begin
            if (!SAFETY_CHAIN)
                state_nxt = S_WDOG;
            else if (timed_out(sec_r, `BSO_CHAIN_SEC))
            begin
                ev_nxt[`BSO_IRQ_RESTART] = 1'b1;
                state_nxt = S_WAIT;
            end
        end
        S_WDOG:
        begin
            // relay output lags one edge; stay until it is energised
            if (WATCHDOG_ENABLE)
                state_nxt = S_LATER;
        end
        S_LATER:
        begin
            // the later program owns this exit
            if (!HEAT_REQ && LATER_PHASE == 3'h0)
                state_nxt = S_WAIT;
        end
        default:
        begin
            state_nxt = S_ERROR;
        end
    endcase
    if (ctrl_r[`BSO_CTRL_FAULT] || LOCKED_OUT)
        state_nxt = S_ERROR;
    if (state_nxt == S_ERROR && state_r != S_ERROR)
        ev_nxt[`BSO_IRQ_ERROR] = 1'b1;
end

always @*
begin
    case (state_r)
        S_ERROR: code_nxt = `BSO_ST_ERROR;
        S_PAUSE: code_nxt = pause_code;
        S_WAIT: code_nxt = `BSO_ST_WAIT;
        S_AIRCHK: code_nxt = `BSO_ST_AIRCHK;
        S_CHAIN: code_nxt = `BSO_ST_CHAIN;
        // chain only carries potential once the relay is energised
        S_WDOG: code_nxt = (SAFETY_CHAIN | ~WATCHDOG_ENABLE) ? `BSO_ST_WDOG
            : `BSO_ST_CHAIN_FAIL;
        default: code_nxt = {5'h10, LATER_PHASE};
    endcase
end

always @(posedge SYS_CLK or negedge ARST_N)
begin
    if (!ARST_N)
    begin
        state_r <= S_WAIT;
        pause_r <= 3'h1;
        sec_r <= 16'h0000;
        relight_r <= 1'b0;
    end
    else
    begin
        state_r <= state_nxt;
        pause_r <= pause_nxt;
        // any press or state change restarts the timeout
        if (state_nxt != state_r || pause_nxt != pause_r || unlock_pulse)
            sec_r <= 16'h0000;
        else if (tick_r && sec_r != 16'hffff)
            sec_r <= sec_r + 16'h0001;
        // relight holds only while the main burner stays off
        if (state_r == S_LATER && LATER_PHASE == `BSO_PH_OPER && MAIN_OFF_REQ
            && cfg_r[`BSO_CFG_RELIGHT])
            relight_r <= 1'b1;
        else if (state_r != S_LATER || !MAIN_OFF_REQ)
            relight_r <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// outputs, all registered
always @(posedge SYS_CLK or negedge ARST_N)
begin
    if (!ARST_N)
    begin
        PRESSURE_BUILD_VALVE <= 1'b0;
        VENT_VALVE <= 1'b1;
        IGNITION_OUTPUT <= 1'b0;
        FAN_AIR_VALVE_OUTPUT <= 1'b0;
        OPERATION_OUTPUT <= 1'b0;
        ALARM_OUTPUT <= 1'b0;
        WATCHDOG_ENABLE <= 1'b0;
        ERROR_PRESENT <= 1'b0;
        READY_OUT <= 1'b0;
        DISPLAY_CODE <= 8'h00;
    end
    else
    begin
        PRESSURE_BUILD_VALVE <= cfg_r[`BSO_CFG_GREASE] & in_preaer;
        VENT_VALVE <= ~(cfg_r[`BSO_CFG_GREASE] & in_grease_win);
        IGNITION_OUTPUT <= (state_r == S_LATER) & ((LATER_PHASE == `BSO_PH_IGNITE)
            | (cfg_r[`BSO_CFG_PREIGN] & in_preaer) | relight_r);
        // fan relay must stay open during the chain check
        FAN_AIR_VALVE_OUTPUT <= ((state_r == S_LATER) & (LATER_PHASE != 3'h0))
            | (ctrl_r[`BSO_CTRL_COOL] & (state_r == S_ERROR | state_r == S_WAIT));
        case (opfn)
            `BSO_OPFN_RUN: OPERATION_OUTPUT <= (state_r == S_LATER)
                & (LATER_PHASE == `BSO_PH_OPER);
            `BSO_OPFN_GREASE: OPERATION_OUTPUT <= cfg_r[`BSO_CFG_GREASE] & in_preaer;
            `BSO_OPFN_READY: OPERATION_OUTPUT <= state_r == S_WAIT;
            default: OPERATION_OUTPUT <= 1'b0;
        endcase
        ALARM_OUTPUT <= (state_r == S_ERROR) | LOCKED_OUT;
        WATCHDOG_ENABLE <= (state_r == S_WDOG) | (state_r == S_LATER);
        ERROR_PRESENT <= state_r == S_ERROR;
        READY_OUT <= state_r == S_WAIT;
        DISPLAY_CODE <= (state_r == S_ERROR) ? errcode_r : code_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// apb slave, zero wait states
always @(posedge SYS_CLK or negedge ARST_N)
begin
    if (!ARST_N)
    begin
        ctrl_r <= 4'h0;
        cfg_r <= 10'h000;
        irq_stat_r <= 3'h0;
        irq_mask_r <= 3'h0;
        errcode_r <= 8'h00;
        tickdiv_r <= `BSO_TICKDIV_RST;
        PRDATA <= 32'h00000000;
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
        IRQ <= 1'b0;
    end
    else
    begin
        PREADY <= PSEL & ~PENABLE;
        PSLVERR <= PSEL & ~PENABLE & ~addr_ok(PADDR);
        // set wins over write-one-clear
        irq_stat_r <= (irq_stat_r & ~((wr_acc && PADDR == `BSO_OFF_IRQ_STAT)
            ? PWDATA[2:0] : 3'h0)) | ev_nxt;
        IRQ <= |(irq_stat_r & irq_mask_r);
        if (wr_acc)
        begin
            case (PADDR)
                `BSO_OFF_CTRL: ctrl_r <= {PWDATA[3:2], 1'b0, PWDATA[0]};
                `BSO_OFF_CFG: cfg_r <= PWDATA[9:0];
                `BSO_OFF_IRQ_MASK: irq_mask_r <= PWDATA[2:0];
                `BSO_OFF_ERRCODE: errcode_r <= PWDATA[7:0];
                `BSO_OFF_TICKDIV: tickdiv_r <= PWDATA;
                default: ;
            endcase
        end
        if (rd_setup)
        begin
            case (PADDR)
                `BSO_OFF_CTRL: PRDATA <= {28'h0000000, ctrl_r};
                `BSO_OFF_CFG: PRDATA <= {22'h000000, cfg_r};
                `BSO_OFF_STATUS: PRDATA <= {16'h0000, DISPLAY_CODE, 1'b0, state_r};
                `BSO_OFF_IRQ_STAT: PRDATA <= {29'h00000000, irq_stat_r};
                `BSO_OFF_IRQ_MASK: PRDATA <= {29'h00000000, irq_mask_r};
                `BSO_OFF_ERRCODE: PRDATA <= {24'h000000, errcode_r};
                `BSO_OFF_TICKDIV: PRDATA <= tickdiv_r;
                default: PRDATA <= 32'h00000000;
            endcase
        end
    end
end

endmodule // bso_top

// file: dv/bso_props.sv
`timescale 1ns/10ps
module bso_props
(
    input wire SYS_CLK,
    input wire ARST_N,
    input wire PSEL,
    input wire PENABLE,
    input wire PREADY,
    input wire PSLVERR,
    input wire LOCKED_OUT,
    input wire [2:0] LATER_PHASE,
    input wire PRESSURE_BUILD_VALVE,
    input wire VENT_VALVE,
    input wire FAN_AIR_VALVE_OUTPUT,
    input wire ALARM_OUTPUT,
    input wire ERROR_PRESENT,
    input wire WATCHDOG_ENABLE,
    input wire READY_OUT,
    input wire [7:0] DISPLAY_CODE
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!ARST_N);
    sequence lock_held;
        LOCKED_OUT [*3];
    endsequence
    sequence recent_preaer;
        $past(LATER_PHASE) == 3'h1 || $past(LATER_PHASE, 2) == 3'h1;
    endsequence
    pbv_preaer_a:
        assert property (PRESSURE_BUILD_VALVE |-> recent_preaer) else $error("pbv open");
    vent_closed_a:
        assert property (!VENT_VALVE |-> $past(LATER_PHASE) inside {[3'h1:3'h3]}
            || $past(LATER_PHASE, 2) inside {[3'h1:3'h3]}) else $error("vent shut");
    lock_alarm_a:
        assert property (lock_held |=> ALARM_OUTPUT && ERROR_PRESENT) else $error("alarm");
    alarm_error_a:
        assert property (ERROR_PRESENT |-> ALARM_OUTPUT) else $error("alarm in error");
    ready_code_a:
        assert property (READY_OUT |-> DISPLAY_CODE == 8'h02 || $past(DISPLAY_CODE) == 8'h02)
            else $error("ready code");
    chain_relay_a:
        assert property (DISPLAY_CODE == 8'h04 |-> !WATCHDOG_ENABLE && !FAN_AIR_VALVE_OUTPUT)
            else $error("relay");
    pready_pulse_a:
        assert property (PREADY |=> !PREADY) else $error("pready long");
    pready_access_a:
        assert property (PREADY |-> PSEL && PENABLE) else $error("pready phase");
    slverr_ready_a:
        assert property (PSLVERR |-> PREADY) else $error("slverr alone");
endmodule // bso_props
bind bso_top bso_props bso_props_inst(.SYS_CLK, .ARST_N, .PSEL, .PENABLE, .PREADY, .PSLVERR,
    .LOCKED_OUT, .LATER_PHASE, .PRESSURE_BUILD_VALVE, .VENT_VALVE, .FAN_AIR_VALVE_OUTPUT,
    .ALARM_OUTPUT,
    .ERROR_PRESENT, .WATCHDOG_ENABLE, .READY_OUT, .DISPLAY_CODE);

// file: dv/bso_plant.sv
`timescale 1ns/10ps
module bso_plant
(
    input wire fan,
    input wire wdog,
    input wire air_mode,
    input wire air_stuck,
    input wire chain_stuck,
    output wire air_sw,
    output wire chain
);
    // air only with fan running, unless the switch is welded
    assign air_sw = (fan | air_stuck) ? air_mode : ~air_mode;
    // energised watchdog puts potential on the chain
    assign chain = chain_stuck | wdog;
endmodule // bso_plant

// file: dv/tb_top.sv
`timescale 1ns/10ps
`include "bso_consts.vh"
module tb_top;
    logic SYS_CLK = '0, ARST_N = '0, PSEL = '0, PENABLE = '0, PWRITE = '0;
    logic [11:0] PADDR = '0;
    logic [31:0] PWDATA = '0, PRDATA, rd;
    logic PARAM_MODE = '0, HEAT_REQ = '0, LOCKED_OUT = '0, MAIN_OFF_REQ = '0;
    logic [2:0] LATER_PHASE = '0;
    logic air_stuck = '0, chain_stuck = '0, irq_a, slv;
    logic PREADY, PSLVERR, AIR_PRESSURE_SWITCH, SAFETY_CHAIN, PRESSURE_BUILD_VALVE;
    logic VENT_VALVE, IGNITION_OUTPUT, FAN_AIR_VALVE_OUTPUT, OPERATION_OUTPUT, ALARM_OUTPUT;
    logic WATCHDOG_ENABLE, ERROR_PRESENT, READY_OUT, IRQ;
    logic [7:0] DISPLAY_CODE;
    int err_total = 0, compares = 0, p;
    bso_top bso_top_inst(.SYS_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .PARAM_MODE, .HEAT_REQ, .AIR_PRESSURE_SWITCH,
        .SAFETY_CHAIN, .LOCKED_OUT, .MAIN_OFF_REQ, .LATER_PHASE, .PRESSURE_BUILD_VALVE,
        .VENT_VALVE, .IGNITION_OUTPUT, .FAN_AIR_VALVE_OUTPUT, .OPERATION_OUTPUT,
        .ALARM_OUTPUT, .WATCHDOG_ENABLE, .ERROR_PRESENT, .READY_OUT, .DISPLAY_CODE, .IRQ);
    bso_plant bso_plant_inst(.fan(FAN_AIR_VALVE_OUTPUT), .wdog(WATCHDOG_ENABLE),
        .air_mode(1'b0), .air_stuck, .chain_stuck, .air_sw(AIR_PRESSURE_SWITCH),
        .chain(SAFETY_CHAIN));
    initial
    begin
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    //////////////////////////////////////////////////////////////////////////
    task results;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    // one idle edge first, so back-to-back calls never drive twice at once
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do @(posedge SYS_CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        slv = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask
    task wc(input logic [7:0] c);
        for (int i = 0; i < 2000 && DISPLAY_CODE !== c; i++) @(posedge SYS_CLK);
        chk("code", c, DISPLAY_CODE);
    endtask
    task tick(input int n);
        repeat (n) @(posedge SYS_CLK);
    endtask
    //////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(4);
        ARST_N <= 1'b1;
        tick(2);
        chk("vent", 32'h1, VENT_VALVE);
        chk("ready", 32'h1, READY_OUT);
        chk("code", 32'h2, DISPLAY_CODE);
        apb(1'b0, `BSO_OFF_TICKDIV, 32'h0);
        chk("tickdiv", `BSO_TICKDIV_RST, rd);
        apb(1'b1, `BSO_OFF_TICKDIV, 32'h3);
        apb(1'b0, 12'h01c, 32'h0);
        chk("slverr", 32'h1, slv);
        chain_stuck <= 1'b1;
        HEAT_REQ <= 1'b1;
        wc(`BSO_ST_CHAIN);
        chk("fan", 32'h0, FAN_AIR_VALVE_OUTPUT);
        chk("wdog", 32'h0, WATCHDOG_ENABLE);
        tick(200);
        apb(1'b0, `BSO_OFF_IRQ_STAT, 32'h0);
        chk("early", 32'h0, rd[`BSO_IRQ_RESTART]);
        tick(60);
        apb(1'b0, `BSO_OFF_IRQ_STAT, 32'h0);
        chk("restart", 32'h1, rd[`BSO_IRQ_RESTART]);
        apb(1'b1, `BSO_OFF_IRQ_MASK, 32'h0);
        tick(2);
        irq_a = IRQ;
        apb(1'b1, `BSO_OFF_IRQ_MASK, 32'h7);
        tick(2);
        chk("irqmask", 32'h1, IRQ ^ irq_a);
        chain_stuck <= 1'b0;
        HEAT_REQ <= 1'b0;
        apb(1'b1, `BSO_OFF_ERRCODE, 32'h11);
        LOCKED_OUT <= 1'b1;
        tick(4);
        chk("alarm", 32'h1, ALARM_OUTPUT);
        chk("error", 32'h1, ERROR_PRESENT);
        chk("errcode", 32'h11, DISPLAY_CODE);
        apb(1'b1, `BSO_OFF_CTRL, 32'h4);
        tick(2);
        chk("cool", 32'h1, FAN_AIR_VALVE_OUTPUT);
        LOCKED_OUT <= 1'b0;
        apb(1'b1, `BSO_OFF_CTRL, 32'h2);
        wc(`BSO_ST_WAIT);
        chk("alarm", 32'h0, ALARM_OUTPUT);
        apb(1'b1, `BSO_OFF_IRQ_STAT, 32'h7);
        apb(1'b0, `BSO_OFF_IRQ_STAT, 32'h0);
        chk("irqstat", 32'h0, rd);
        chk("irq", 32'h0, IRQ);
        air_stuck <= 1'b1;
        HEAT_REQ <= 1'b1;
        wc(`BSO_ST_AIRCHK);
        tick(440);
        chk("code", 32'h3, DISPLAY_CODE);
        tick(80);
        apb(1'b0, `BSO_OFF_IRQ_STAT, 32'h0);
        chk("restart", 32'h1, rd[`BSO_IRQ_RESTART]);
        // heat request stays on so the start-up runs into the later program
        apb(1'b1, `BSO_OFF_CFG, 32'h107);
        air_stuck <= 1'b0;
        wc(`BSO_ST_WDOG);
        tick(4);
        chk("wdog", 32'h1, WATCHDOG_ENABLE);
        for (p = 0; p < 6; p++)
        begin
            LATER_PHASE <= p[2:0];
            tick(3);
            chk("pbv", p == 1, PRESSURE_BUILD_VALVE);
            chk("vent", !(p >= 1 && p <= 3), VENT_VALVE);
            chk("ign", p == 1 || p == 2, IGNITION_OUTPUT);
            if (p == 4)
                chk("op", 32'h1, OPERATION_OUTPUT);
        end
        LATER_PHASE <= `BSO_PH_OPER;
        MAIN_OFF_REQ <= 1'b1;
        tick(3);
        chk("relight", 32'h1, IGNITION_OUTPUT);
        apb(1'b1, `BSO_OFF_CFG, 32'h7);
        tick(2);
        chk("op", 32'h0, OPERATION_OUTPUT);
        LATER_PHASE <= 3'h0;
        MAIN_OFF_REQ <= 1'b0;
        HEAT_REQ <= 1'b0;
        PARAM_MODE <= 1'b1;
        wc(`BSO_ST_PAUSE1);
        apb(1'b1, `BSO_OFF_CTRL, 32'ha);
        tick(2);
        chk("step", 32'h2, DISPLAY_CODE);
        PARAM_MODE <= 1'b0;
        tick(4);
        chk("early exit", 32'h1, ERROR_PRESENT);
        apb(1'b1, `BSO_OFF_CTRL, 32'h2);
        wc(`BSO_ST_WAIT);
        apb(1'b1, `BSO_OFF_CFG, 32'h300);
        tick(2);
        chk("op ready", 32'h1, OPERATION_OUTPUT);
        apb(1'b1, `BSO_OFF_CFG, 32'h10);
        PARAM_MODE <= 1'b1;
        wc(`BSO_ST_PAUSE1);
        tick(7000);
        chk("pause", 32'h0, ERROR_PRESENT);
        tick(400);
        chk("pause", 32'h1, ERROR_PRESENT);
        results;
    end
    // run needs about 8300 cycles
    initial
    begin
        tick(30000);
        err_total++;
        results;
    end
endmodule // tb_top
